//--- fpgcd_regs.svh
// Register offsets, field positions, reset values and codes of the decoder.
`ifndef FPGCD_REGS_SVH
`define FPGCD_REGS_SVH
`define OFS_OPWORD 6'h00
`define OFS_CMDWORD 6'h04
`define OFS_EXC_ENABLE 6'h08
`define OFS_DECODE 6'h0c
`define OFS_SERVICE 6'h10
`define OFS_LIST 6'h14
`define RST_OPWORD 16'h0000
`define RST_CMDWORD 16'h0000
`define RST_EXC_ENABLE 8'h00
`define EXC_BRANCH_UNORDERED_EXCEPTION_MASK 8'h80
`define VEC_EMULATOR 8'h0b
`define GENERAL_LINE 7'h78
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define DEC_CLS_POS 0
`define DEC_OPER_POS 4
`define DEC_SRC_POS 9
`define DEC_DST_POS 12
`define DEC_FMT_POS 15
`define DEC_EXT_POS 18
`define DEC_DYADIC_POS 25
`define SVC_FIRST_POS 0
`define SVC_SECOND_POS 2
`define SVC_CA_POS 4
`define SVC_PC_POS 5
`define SVC_DATA_EA_POS 6
`define SVC_EXT_WARN_POS 7
`define SVC_NOT_GEN_POS 8
`define SVC_LEN_POS 12
`define SVC_VEC_POS 16
`define SVC_VALID_POS 24
`define LST_LIST_POS 0
`define LST_HOSTREG_POS 8
`define LST_MODE_POS 11
`endif

//--- fpgcd_pkg.sv
// Types shared by the general command decoder.
package fpgcd_pkg;
	typedef enum logic [3:0] {
		CLS_REG2REG = 4'h0,
		CLS_RESERVED = 4'h1,
		CLS_EXT2REG = 4'h2,
		CLS_CONST = 4'h3,
		CLS_STORE = 4'h4,
		CLS_CTRL_LOAD = 4'h5,
		CLS_CTRL_STORE = 4'h6,
		CLS_MULTI_LOAD = 4'h7,
		CLS_MULTI_STORE = 4'h8
	} cls_t;
	typedef enum logic [1:0] {
		PRIM_NONE = 2'h0,
		PRIM_NULL = 2'h1,
		PRIM_EVAL_XFER = 2'h2,
		PRIM_PREINSTR_EXC = 2'h3
	} prim_t;
	typedef enum logic [4:0] {
		OP_MOVE = 5'h00, OP_INT = 5'h01, OP_INTRZ = 5'h02,
		OP_SQRT = 5'h03, OP_ABS = 5'h04, OP_NEG = 5'h05,
		OP_TRANSC = 5'h06, OP_DIV = 5'h07, OP_MOD = 5'h08,
		OP_ADD = 5'h09, OP_MUL = 5'h0a, OP_SGLDIV = 5'h0b,
		OP_REM = 5'h0c, OP_SCALE = 5'h0d, OP_SGLMUL = 5'h0e,
		OP_SUB = 5'h0f, OP_SINCOS = 5'h10, OP_CMP = 5'h11,
		OP_TST = 5'h12, OP_REDUNDANT = 5'h13, OP_UNDEF = 5'h14,
		OP_NONE = 5'h15
	} oper_t;
	typedef struct packed {
		cls_t cls;
		oper_t oper;
		logic [2:0] src;
		logic [2:0] dst;
		logic [2:0] fmt;
		logic [6:0] ext;
		logic dyadic;
		prim_t first;
		prim_t second;
		logic come_again_bit;
		logic pc_req;
		logic [7:0] vector;
		logic [3:0] length;
		logic data_ea;
		logic ext_warn;
		logic not_general;
		logic [7:0] list;
	} decode_t;
endpackage

//--- fp_general_command_decoder.sv
// General-type command decoder of the floating-point coprocessor.
`include "fpgcd_regs.svh"

module fp_general_command_decoder
	import fpgcd_pkg::*;
#(
	parameter int ADDR_W = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output decode_t dec,
	output logic dec_strobe
);
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Byte length of an external operand; code 111 only arises on stores.
	function automatic logic [3:0] fmt_length(input logic [2:0] f);
		unique case (f)
			3'b000, 3'b001: fmt_length = 4'h4;
			3'b010, 3'b011, 3'b111: fmt_length = 4'hc;
			3'b100: fmt_length = 4'h2;
			3'b101: fmt_length = 4'h8;
			3'b110: fmt_length = 4'h1;
		endcase
	endfunction

	// Formats that may live in a host data register.
	function automatic logic fmt_data_ea(input logic [2:0] f);
		fmt_data_ea = (f == 3'b000) || (f == 3'b001) ||
			(f == 3'b100) || (f == 3'b110);
	endfunction

	function automatic oper_t ext_oper(input logic [6:0] e);
		if (e[6])
			ext_oper = OP_UNDEF;
		else if (!e[5]) begin
			unique case (e[4:0])
				5'h00: ext_oper = OP_MOVE;
				5'h01: ext_oper = OP_INT;
				5'h03: ext_oper = OP_INTRZ;
				5'h04: ext_oper = OP_SQRT;
				5'h18: ext_oper = OP_ABS;
				5'h1a: ext_oper = OP_NEG;
				default: ext_oper = OP_TRANSC;
			endcase
		end else if (e[4:3] == 2'b10)
			ext_oper = OP_SINCOS;
		else begin
			unique case (e[4:0])
				5'h00: ext_oper = OP_DIV;
				5'h01: ext_oper = OP_MOD;
				5'h02: ext_oper = OP_ADD;
				5'h03: ext_oper = OP_MUL;
				5'h04: ext_oper = OP_SGLDIV;
				5'h05: ext_oper = OP_REM;
				5'h06: ext_oper = OP_SCALE;
				5'h07: ext_oper = OP_SGLMUL;
				5'h08: ext_oper = OP_SUB;
				5'h18: ext_oper = OP_CMP;
				5'h1a: ext_oper = OP_TST;
				default: ext_oper = OP_REDUNDANT;
			endcase
		end
	endfunction

	logic [15:0] opword;
	logic [15:0] cmdword;
	logic [7:0] exc_enable;
	logic dec_pending;
	logic dec_valid;
	logic aw_got;
	logic w_got;
	logic [ADDR_W-1:0] waddr;
	logic [31:0] wbuf;
	logic [3:0] wbuf_strb;

	wire aw_hs = awvalid && awready;
	wire w_hs = wvalid && wready;
	wire ar_hs = arvalid && arready;
	wire wr_fire = aw_got && w_got && !bvalid;
	wire next_aw_got = aw_got ? !wr_fire : aw_hs;
	wire next_w_got = w_got ? !wr_fire : w_hs;
	wire next_rvalid = rvalid ? !rready : ar_hs;
	wire next_bvalid = bvalid ? !bready : wr_fire;

	wire wr_opword = wr_fire && (waddr == `OFS_OPWORD);
	wire wr_cmdword = wr_fire && (waddr == `OFS_CMDWORD);
	wire wr_exc = wr_fire && (waddr == `OFS_EXC_ENABLE);
	wire wr_mapped = wr_opword || wr_cmdword || wr_exc ||
		(waddr == `OFS_DECODE) || (waddr == `OFS_SERVICE) ||
		(waddr == `OFS_LIST);

	// Command word fields: class, source, destination, extension.
	wire [2:0] opclass = cmdword[15:13];
	wire [2:0] rx = cmdword[12:10];
	wire [2:0] ry = cmdword[9:7];
	wire [6:0] ext = cmdword[6:0];
	// The operation word must be a general-type line for this decoder.
	wire not_general = (opword[15:9] & 7'h78) != `GENERAL_LINE ||
		opword[8:6] != 3'b000;
	// Any enabled exception except branch-unordered needs the host PC.
	wire pc_need = |(exc_enable & ~`EXC_BRANCH_UNORDERED_EXCEPTION_MASK);

	cls_t next_cls;
	always_comb begin
		unique case (opclass)
			3'b000: next_cls = CLS_REG2REG;
			3'b001: next_cls = CLS_RESERVED;
			3'b010: next_cls = (rx == 3'b111) ? CLS_CONST : CLS_EXT2REG;
			3'b011: next_cls = CLS_STORE;
			3'b100: next_cls = CLS_CTRL_LOAD;
			3'b101: next_cls = CLS_CTRL_STORE;
			3'b110: next_cls = CLS_MULTI_LOAD;
			3'b111: next_cls = CLS_MULTI_STORE;
		endcase
	end

	wire is_arith = (next_cls == CLS_REG2REG) ||
		(next_cls == CLS_EXT2REG);
	// The effective-address field plays no part in internal ops.
	wire trap = (is_arith && ext[6]) ||
		(next_cls == CLS_RESERVED);
	wire is_ext_xfer = !trap && next_cls != CLS_REG2REG &&
		next_cls != CLS_CONST;
	wire packed_store = (rx == 3'b011) || (rx == 3'b111);
	wire ext_warn = ((next_cls == CLS_CTRL_LOAD ||
		next_cls == CLS_CTRL_STORE) && (ext != 7'h00 ||
		ry != 3'b000)) ||
		(next_cls == CLS_STORE && !packed_store &&
		ext != 7'h00);

	decode_t next_dec;
	always_comb begin
		next_dec = '0;
		next_dec.cls = next_cls;
		next_dec.oper = is_arith ? ext_oper(ext) : OP_NONE;
		next_dec.ext = ext;
		next_dec.not_general = not_general;
		next_dec.ext_warn = ext_warn;
		next_dec.pc_req = pc_need && !trap;
		// Two-operand ops also read the destination and overwrite it.
		next_dec.dyadic = is_arith && ext[5] && !ext[6];
		// Register fields select data registers zero to seven as coded.
		next_dec.dst = (next_cls == CLS_STORE) ? 3'b000 : ry;
		next_dec.src = (next_cls == CLS_STORE) ? ry : rx;
		if (next_cls != CLS_REG2REG) begin
			next_dec.fmt = rx;
			next_dec.length = fmt_length(rx);
			next_dec.data_ea = fmt_data_ea(rx);
		end
		if (next_cls == CLS_REG2REG)
			next_dec.src = rx;
		if (next_cls == CLS_CONST)
			next_dec.fmt = 3'b000;
		if (next_cls == CLS_STORE && !packed_store)
			next_dec.ext = 7'h00;
		if (next_cls == CLS_MULTI_LOAD || next_cls == CLS_MULTI_STORE)
			next_dec.list = {ry[0], ext};
		if (next_cls == CLS_CTRL_LOAD || next_cls == CLS_CTRL_STORE)
			next_dec.list = {5'h00, rx};
		if (trap) begin
			next_dec.first = PRIM_PREINSTR_EXC;
			next_dec.vector = `VEC_EMULATOR;
		end else if (next_cls == CLS_REG2REG) begin
			next_dec.first = PRIM_NULL;
		end else if (next_cls == CLS_CONST) begin
			// Offset into the constant memory rides in the extension.
			next_dec.first = PRIM_NULL;
			next_dec.come_again_bit = 1'b1;
		end else if (next_cls == CLS_EXT2REG) begin
			next_dec.first = PRIM_EVAL_XFER;
			next_dec.come_again_bit = 1'b1;
			next_dec.second = PRIM_NULL;
		end else if (is_ext_xfer) begin
			next_dec.first = PRIM_EVAL_XFER;
		end
	end

	wire [31:0] decode_word =
		(32'(dec.cls) << `DEC_CLS_POS) |
		(32'(dec.oper) << `DEC_OPER_POS) |
		(32'(dec.src) << `DEC_SRC_POS) |
		(32'(dec.dst) << `DEC_DST_POS) |
		(32'(dec.fmt) << `DEC_FMT_POS) |
		(32'(dec.ext) << `DEC_EXT_POS) |
		(32'(dec.dyadic) << `DEC_DYADIC_POS);
	wire [31:0] service_word =
		(32'(dec.first) << `SVC_FIRST_POS) |
		(32'(dec.second) << `SVC_SECOND_POS) |
		(32'(dec.come_again_bit) << `SVC_CA_POS) |
		(32'(dec.pc_req) << `SVC_PC_POS) |
		(32'(dec.data_ea) << `SVC_DATA_EA_POS) |
		(32'(dec.ext_warn) << `SVC_EXT_WARN_POS) |
		(32'(dec.not_general) << `SVC_NOT_GEN_POS) |
		(32'(dec.length) << `SVC_LEN_POS) |
		(32'(dec.vector) << `SVC_VEC_POS) |
		(32'(dec_valid) << `SVC_VALID_POS);
	wire [31:0] list_word =
		(32'(dec.list) << `LST_LIST_POS) |
		(32'(dec.ext[6:4]) << `LST_HOSTREG_POS) |
		(32'(rx) << `LST_MODE_POS);

	wire rd_hit = (araddr == `OFS_OPWORD) || (araddr == `OFS_CMDWORD) ||
		(araddr == `OFS_EXC_ENABLE) || (araddr == `OFS_DECODE) ||
		(araddr == `OFS_SERVICE) || (araddr == `OFS_LIST);
	wire [31:0] rd_mux =
		(araddr == `OFS_OPWORD) ? {16'h0000, opword} :
		(araddr == `OFS_CMDWORD) ? {16'h0000, cmdword} :
		(araddr == `OFS_EXC_ENABLE) ? {24'h000000, exc_enable} :
		(araddr == `OFS_DECODE) ? decode_word :
		(araddr == `OFS_SERVICE) ? service_word :
		(araddr == `OFS_LIST) ? list_word : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			waddr <= '0;
			wbuf <= 32'h00000000;
			wbuf_strb <= 4'h0;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			awready <= !next_aw_got;
			wready <= !next_w_got;
			bvalid <= next_bvalid;
			if (aw_hs)
				waddr <= awaddr;
			if (w_hs) begin
				wbuf <= wdata;
				wbuf_strb <= wstrb;
			end
			if (wr_fire)
				bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else begin
			arready <= !next_rvalid;
			rvalid <= next_rvalid;
			if (ar_hs) begin
				rdata <= rd_mux;
				rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// Decoding waits one cycle so that it sees the stored command word.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opword <= `RST_OPWORD;
			cmdword <= `RST_CMDWORD;
			exc_enable <= `RST_EXC_ENABLE;
			dec_pending <= 1'b0;
			dec_valid <= 1'b0;
			dec_strobe <= 1'b0;
			dec <= '0;
		end else begin
			if (wr_opword)
				opword <= merge16(opword, wbuf, wbuf_strb);
			if (wr_cmdword)
				cmdword <= merge16(cmdword, wbuf, wbuf_strb);
			if (wr_exc && wbuf_strb[0])
				exc_enable <= wbuf[7:0];
			dec_pending <= wr_cmdword;
			dec_strobe <= dec_pending;
			if (dec_pending)
				dec <= next_dec;
			if (dec_pending)
				dec_valid <= 1'b1;
			else if (wr_opword)
				dec_valid <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence cmd_write_s;
		wr_cmdword;
	endsequence
	sequence decode_done_s;
		##2 dec_strobe;
	endsequence

	decode_timing_a:
	assert property (cmd_write_s |-> decode_done_s)
		else $error("Decode strobe missing two cycles after command.");

	bresp_hold_a:
	assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("Write response dropped before acceptance.");

	unmapped_read_a:
	assert property (ar_hs && !rd_hit |=> rvalid &&
		rresp == `RESP_SLVERR)
		else $error("Unmapped read not answered with an error.");

	undef_trap_a:
	assert property (dec_strobe && (dec.cls == CLS_REG2REG ||
		dec.cls == CLS_EXT2REG) && dec.ext[6] |->
		dec.first == PRIM_PREINSTR_EXC && dec.vector == 8'h0b)
		else $error("Undefined extension code did not request trap.");

	ext_dialog_a:
	assert property (dec_strobe && dec.cls == CLS_EXT2REG &&
		!dec.ext[6] |-> dec.first == PRIM_EVAL_XFER &&
		dec.come_again_bit && dec.second == PRIM_NULL)
		else $error("External operand dialog primitives wrong.");

	pc_request_a:
	assert property (dec_strobe && dec.cls == CLS_REG2REG &&
		!dec.ext[6] |-> dec.first == PRIM_NULL &&
		dec.pc_req == |(exc_enable & 8'h7f))
		else $error("Register operation null or pc bit wrong.");

	fmt_length_a:
	assert property (dec_strobe && dec.cls == CLS_EXT2REG |->
		(dec.fmt != 3'b010 || dec.length == 4'hc) &&
		(dec.fmt != 3'b101 || dec.length == 4'h8) &&
		(dec.fmt != 3'b110 || dec.length == 4'h1))
		else $error("External operand length wrong.");

	reg_fields_a:
	assert property (dec_strobe && dec.cls == CLS_REG2REG |->
		dec.src == cmdword[12:10] && dec.dst == cmdword[9:7])
		else $error("Register fields not mapped directly.");

	const_load_a:
	assert property (dec_strobe && dec.cls == CLS_CONST |->
		dec.first == PRIM_NULL && dec.come_again_bit &&
		dec.ext == cmdword[6:0])
		else $error("Constant load decode wrong.");

	store_ext_a:
	assert property (dec_strobe && dec.cls == CLS_STORE &&
		dec.fmt != 3'b011 && dec.fmt != 3'b111 |-> dec.ext == 7'h00)
		else $error("Store extension not cleared for plain format.");
endmodule

//--- fpgcd_host.sv
// Host-side register bus master that hands commands to the decoder.
module fpgcd_host (
	input wire logic aclk,
	input wire logic awready,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic [5:0] awaddr,
	output logic awvalid,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	output logic bready,
	output logic [5:0] araddr,
	output logic arvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// A wait that runs out raises this so the bench can close the run.
	bit hung = 1'b0;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Released payloads are inverted so a stale value never looks valid.
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ga;
		logic gw;
		ga = 1'b0;
		gw = 1'b0;
		r = 2'bxx;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (!ga && awready) begin
				ga = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!gw && wready) begin
				gw = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (r === 2'bxx)
			hung = 1'b1;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ga;
		ga = 1'b0;
		r = 2'bxx;
		d = 'x;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (!ga && arready) begin
				ga = 1'b1;
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (r === 2'bxx)
			hung = 1'b1;
	endtask
endmodule

//--- tb_fp_general_command_decoder.sv
// Self-checking bench of the general command decoder.
`include "fpgcd_regs.svh"
module tb_fp_general_command_decoder
	import fpgcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [2:0] awprot = 3'h0;
	logic [2:0] arprot = 3'h0;
	logic [5:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, dec_strobe;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [7:0] ena;
	decode_t dec, seen;
	logic [15:0] last_cmd;
	logic [5:0] rst_ofs [3] = '{`OFS_OPWORD, `OFS_CMDWORD, `OFS_EXC_ENABLE};
	logic [31:0] rst_val [3] = '{{16'h0, `RST_OPWORD},
		{16'h0, `RST_CMDWORD}, {24'h0, `RST_EXC_ENABLE}};
	int error_cnt = 0;
	int checked = 0;
	int strobes = 0;
	fp_general_command_decoder i_fp_general_command_decoder (.aclk,
		.aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .dec,
		.dec_strobe);
	fpgcd_host i_fpgcd_host (.aclk, .awready, .wready, .bresp, .bvalid,
		.arready, .rdata, .rresp, .rvalid, .awaddr, .awvalid, .wdata,
		.wstrb, .wvalid, .bready, .araddr, .arvalid, .rready);
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		if (dec_strobe === 1'b1) begin
			seen <= dec;
			strobes <= strobes + 1;
		end
	end
	always @(posedge aclk) begin
		if (i_fpgcd_host.hung) begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task automatic results;
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [3:0] exp_len(input logic [2:0] f);
		case (f)
			3'h0, 3'h1: return 4'h4;
			3'h4: return 4'h2;
			3'h5: return 4'h8;
			3'h6: return 4'h1;
			default: return 4'hc;
		endcase
	endfunction
	// Redundant codes of the dyadic half decode as OP_REDUNDANT.
	function automatic oper_t exp_op(input logic [6:0] e);
		case (e) inside
			7'h00: return OP_MOVE;
			7'h01: return OP_INT;
			7'h03: return OP_INTRZ;
			7'h04: return OP_SQRT;
			7'h18: return OP_ABS;
			7'h1a: return OP_NEG;
			7'h02, [7'h05:7'h17], 7'h19, [7'h1b:7'h1f]: return OP_TRANSC;
			[7'h29:7'h2f], 7'h39, [7'h3b:7'h3f]: return OP_REDUNDANT;
			[7'h20:7'h28]: return oper_t'(5'(e - 7'h20 + 7'h07));
			[7'h30:7'h37]: return OP_SINCOS;
			7'h38: return OP_CMP;
			7'h3a: return OP_TST;
			default: return OP_NONE;
		endcase
	endfunction
	function automatic cls_t exp_cls(input logic [2:0] c, input logic [2:0] x);
		if (c == 3'h2)
			return (x == 3'h7) ? CLS_CONST : CLS_EXT2REG;
		return (c < 3'h2) ? cls_t'({1'b0, c}) : cls_t'({1'b0, c} + 4'h1);
	endfunction
	task automatic issue(input logic [15:0] opw, input logic [15:0] cmd);
		logic [2:0] c, rx, ry;
		logic [6:0] e;
		int s0;
		logic trap;
		c = cmd[15:13];
		rx = cmd[12:10];
		ry = cmd[9:7];
		e = cmd[6:0];
		last_cmd = cmd;
		trap = c == 3'h1 || (c == 3'h0 || (c == 3'h2 && rx != 3'h7)) && e[6];
		s0 = strobes;
		i_fpgcd_host.wr(`OFS_OPWORD, {16'h0, opw}, r);
		chk("bresp", r, `RESP_OKAY);
		i_fpgcd_host.wr(`OFS_CMDWORD, {16'h0, cmd}, r);
		chk("bresp", r, `RESP_OKAY);
		for (int n = 0; n < 20 && strobes == s0; n++)
			@(posedge aclk);
		if (strobes == s0) begin
			error_cnt++;
			results();
		end
		repeat (3) @(posedge aclk);
		chk("strobe count", strobes, s0 + 1);
		chk("cls", seen.cls, exp_cls(c, rx));
		chk("not general", seen.not_general, 1'b0);
		if (trap) begin
			chk("first", seen.first, PRIM_PREINSTR_EXC);
			chk("vector", seen.vector, `VEC_EMULATOR);
		end else if (c == 3'h0 || c == 3'h2) begin
			chk("dst", seen.dst, ry);
			chk("pc", seen.pc_req, |(ena & ~`EXC_BRANCH_UNORDERED_EXCEPTION_MASK));
			if (c == 3'h0 || rx != 3'h7) begin
				chk("oper", seen.oper, exp_op(e));
				chk("dyadic", seen.dyadic, e[5]);
			end
			if (c == 3'h0) begin
				chk("src", seen.src, rx);
				chk("first", seen.first, PRIM_NULL);
			end else if (rx == 3'h7) begin
				chk("ext", seen.ext, e);
				chk("oper", seen.oper, OP_NONE);
				chk("first", seen.first, PRIM_NULL);
				chk("ca", seen.come_again_bit, 1'b1);
			end else begin
				chk("fmt", seen.fmt, rx);
				chk("len", seen.length, exp_len(rx));
				chk("data ea", seen.data_ea, rx inside {0, 1, 4, 6});
				chk("first", seen.first, PRIM_EVAL_XFER);
				chk("ca", seen.come_again_bit, 1'b1);
				chk("second", seen.second, PRIM_NULL);
			end
		end else begin
			chk("first", seen.first, PRIM_EVAL_XFER);
			if (c == 3'h3) begin
				chk("src", seen.src, ry);
				chk("fmt", seen.fmt, rx);
				chk("len", seen.length, exp_len(rx));
			end
			if (c >= 3'h6)
				chk("list", seen.list, {ry[0], e});
			if (c == 3'h4 || c == 3'h5) begin
				chk("list", seen.list, {5'h00, rx});
				chk("warn", seen.ext_warn, |e || |ry);
			end
		end
	endtask
	initial begin
		repeat (100000) @(posedge aclk);
		error_cnt++;
		results();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(86));
		foreach (rst_ofs[i]) begin
			i_fpgcd_host.rd(rst_ofs[i], d, r);
			chk("reset value", d, rst_val[i]);
			chk("reset resp", r, `RESP_OKAY);
		end
		i_fpgcd_host.rd(6'h18, d, r);
		chk("unmapped resp", r, `RESP_SLVERR);
		chk("unmapped data", d, 32'h0);
		i_fpgcd_host.wr(6'h1c, 32'hffff_ffff, r);
		chk("unmapped wresp", r, `RESP_SLVERR);
		ena = `EXC_BRANCH_UNORDERED_EXCEPTION_MASK;
		i_fpgcd_host.wr(`OFS_EXC_ENABLE, {24'h0, ena}, r);
		// Every extension code on class 000 with random unused address.
		for (int e = 0; e < 128; e++)
			issue(16'hf200 | 16'($urandom % 64), {3'h0, 3'($urandom),
				(e % 4 == 0) ? 3'h5 : 3'($urandom), 7'(e)});
		ena = 8'($urandom) | 8'h01;
		i_fpgcd_host.wr(`OFS_EXC_ENABLE, {24'h0, ena}, r);
		i_fpgcd_host.rd(`OFS_EXC_ENABLE, d, r);
		chk("exc enable", d, {24'h0, ena});
		for (int f = 0; f < 16; f++)
			issue(16'hf210, {3'h2, 3'(f), 3'($urandom), f[3], 6'($urandom)});
		for (int k = 0; k < 40; k++)
			issue(16'hf200 | 16'($urandom % 64), 16'($urandom));
		i_fpgcd_host.rd(`OFS_DECODE, d, r);
		chk("decode reg", d[`DEC_CLS_POS +: 4],
			exp_cls(last_cmd[15:13], last_cmd[12:10]));
		i_fpgcd_host.rd(`OFS_SERVICE, d, r);
		chk("service valid", d[`SVC_VALID_POS], 1'b1);
		i_fpgcd_host.wr(`OFS_OPWORD, 32'h0000_f200, r);
		chk("bresp", r, `RESP_OKAY);
		i_fpgcd_host.rd(`OFS_SERVICE, d, r);
		chk("service cleared", d[`SVC_VALID_POS], 1'b0);
		results();
	end
endmodule
